// ---- rtl/csdec_map.svh ----
`ifndef CSDEC_MAP_SVH
`define CSDEC_MAP_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define CSDEC_SEL0_LOW_IDX   10'h0A8
`define CSDEC_SEL0_HIGH_IDX  10'h0A9
`define CSDEC_SEL0_CTL_IDX   10'h0AA
`define CSDEC_SEL1_LOW_IDX   10'h0AB
`define CSDEC_SEL1_HIGH_IDX  10'h0AC
`define CSDEC_SEL1_CTL_IDX   10'h0AD
`define CSDEC_SEL2_LOW_IDX   10'h0AE
`define CSDEC_SEL2_HIGH_IDX  10'h0AF
`define CSDEC_SEL2_CTL_IDX   10'h0B0
`define CSDEC_SEL3_LOW_IDX   10'h0B1
`define CSDEC_SEL3_HIGH_IDX  10'h0B2
`define CSDEC_SEL3_CTL_IDX   10'h0B3
`define CSDEC_PROTO_IDX      10'h0B4
`define CSDEC_STATUS_IDX     10'h0B5

// ----------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------
`define CSDEC_WAIT_MSB       7
`define CSDEC_WAIT_LSB       5
`define CSDEC_IO_BIT         4
`define CSDEC_EN_BIT         3
`define CSDEC_RSVD_BITS      3'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSDEC_LOW_RST        8'h00
`define CSDEC_HIGH0_RST      8'hFF
`define CSDEC_HIGHN_RST      8'h00
`define CSDEC_CTL0_RST       8'hE8
`define CSDEC_CTLN_RST       8'h00
`define CSDEC_PROTO_RST      4'h0

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define CSDEC_RESP_OKAY      2'h0
`define CSDEC_RESP_SLVERR    2'h2

`endif

// ---- rtl/csdec_pkg.sv ----
package csdec_pkg;

  localparam int CSDEC_CHANNELS = 4;

  typedef struct packed {
    logic [7:0] range_low_byte;
    logic [7:0] range_high_byte;
    logic [2:0] wait_state_count;
    logic       io_type_flag;
    logic       select_enable_flag;
  } csdec_chan_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        mem_req;
    logic        io_req;
  } csdec_bus_req_t;

endpackage

// ---- rtl/csdec_top.sv ----
`timescale 1ns/10ps
`include "csdec_map.svh"

module csdec_top
  import csdec_pkg::*;
(
  // Clock, reset, enable
  input  wire logic           clk_in,
  input  wire logic           rst_b_in,
  input  wire logic           ce_in,
  // AXI4-Lite write address
  input  wire logic [11:0]    s_axi_awaddr_in,
  input  wire logic           s_axi_awvalid_in,
  output logic                s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [31:0]    s_axi_wdata_in,
  input  wire logic [3:0]     s_axi_wstrb_in,
  input  wire logic           s_axi_wvalid_in,
  output logic                s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]          s_axi_bresp_out,
  output logic                s_axi_bvalid_out,
  input  wire logic           s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [11:0]    s_axi_araddr_in,
  input  wire logic           s_axi_arvalid_in,
  output logic                s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0]         s_axi_rdata_out,
  output logic [1:0]          s_axi_rresp_out,
  output logic                s_axi_rvalid_out,
  input  wire logic           s_axi_rready_in,
  // External address bus
  input  wire csdec_bus_req_t bus_req_in,
  // Selects and wait request
  output logic [3:0]          select_output_line_b_out,
  output logic                wait_request_out
);

  // ----------------------------------------------------------------
  // Register index table
  // ----------------------------------------------------------------
  localparam logic [9:0] LOW_IDX [CSDEC_CHANNELS] = '{
    `CSDEC_SEL0_LOW_IDX, `CSDEC_SEL1_LOW_IDX,
    `CSDEC_SEL2_LOW_IDX, `CSDEC_SEL3_LOW_IDX};
  localparam logic [9:0] HIGH_IDX [CSDEC_CHANNELS] = '{
    `CSDEC_SEL0_HIGH_IDX, `CSDEC_SEL1_HIGH_IDX,
    `CSDEC_SEL2_HIGH_IDX, `CSDEC_SEL3_HIGH_IDX};
  localparam logic [9:0] CTL_IDX [CSDEC_CHANNELS] = '{
    `CSDEC_SEL0_CTL_IDX, `CSDEC_SEL1_CTL_IDX,
    `CSDEC_SEL2_CTL_IDX, `CSDEC_SEL3_CTL_IDX};

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  csdec_chan_t chan [CSDEC_CHANNELS];
  logic [3:0]  proto_other;
  logic        aw_held;
  logic [9:0]  aw_idx;
  logic        w_held;
  logic [7:0]  w_byte;
  logic        w_lane;
  logic        do_write;
  logic        wr_hit;
  logic [9:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [3:0]  hit;
  logic [3:0]  winner;
  logic [2:0]  next_wait;
  logic        req_now;
  logic        req_prev;
  logic        access_start;
  logic [2:0]  wait_cnt;
  logic [3:0]  sel_active;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready_out = ce_in && !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = ce_in && !w_held && !s_axi_bvalid_out;
  assign do_write          = ce_in && aw_held && w_held && !s_axi_bvalid_out;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held <= 1'b0;
      aw_idx  <= 10'h000;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_idx  <= s_axi_awaddr_in[11:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata_in[7:0];
      w_lane <= s_axi_wstrb_in[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    wr_hit = (aw_idx == `CSDEC_PROTO_IDX) || (aw_idx == `CSDEC_STATUS_IDX);
    for (int c = 0; c < CSDEC_CHANNELS; c++) begin
      if (aw_idx == LOW_IDX[c] || aw_idx == HIGH_IDX[c] || aw_idx == CTL_IDX[c]) begin
        wr_hit = 1'b1;
      end
    end
  end

  // Status is read-only; a write there is accepted and dropped
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `CSDEC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? `CSDEC_RESP_OKAY : `CSDEC_RESP_SLVERR;
    end else if (ce_in && s_axi_bvalid_out && s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < CSDEC_CHANNELS; c++) begin : g_chan
    localparam logic [7:0] HIGH_RST = (c == 0) ? `CSDEC_HIGH0_RST : `CSDEC_HIGHN_RST;
    localparam logic [7:0] CTL_RST  = (c == 0) ? `CSDEC_CTL0_RST : `CSDEC_CTLN_RST;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        chan[c].range_low_byte     <= `CSDEC_LOW_RST;
        chan[c].range_high_byte    <= HIGH_RST;
        chan[c].wait_state_count   <= CTL_RST[`CSDEC_WAIT_MSB:`CSDEC_WAIT_LSB];
        chan[c].io_type_flag       <= CTL_RST[`CSDEC_IO_BIT];
        chan[c].select_enable_flag <= CTL_RST[`CSDEC_EN_BIT];
      end else if (do_write && w_lane) begin
        if (aw_idx == LOW_IDX[c]) begin
          chan[c].range_low_byte <= w_byte;
        end
        if (aw_idx == HIGH_IDX[c]) begin
          chan[c].range_high_byte <= w_byte;
        end
        // Bits 2:0 have no storage, so they cannot be set
        if (aw_idx == CTL_IDX[c]) begin
          chan[c].wait_state_count   <= w_byte[`CSDEC_WAIT_MSB:`CSDEC_WAIT_LSB];
          chan[c].io_type_flag       <= w_byte[`CSDEC_IO_BIT];
          chan[c].select_enable_flag <= w_byte[`CSDEC_EN_BIT];
        end
      end
    end

    // Memory: inclusive range on the top byte; I/O: match on the middle byte
    always_comb begin
      if (!chan[c].select_enable_flag) begin
        hit[c] = 1'b0;
      end else if (!chan[c].io_type_flag) begin
        hit[c] = bus_req_in.mem_req &&
                 (bus_req_in.addr[23:16] >= chan[c].range_low_byte) &&
                 (bus_req_in.addr[23:16] <= chan[c].range_high_byte);
      end else begin
        hit[c] = bus_req_in.io_req &&
                 (bus_req_in.addr[15:8] == chan[c].range_low_byte);
      end
    end
  end

  // ----------------------------------------------------------------
  // Protocol register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      proto_other <= `CSDEC_PROTO_RST;
    end else if (do_write && w_lane && aw_idx == `CSDEC_PROTO_IDX) begin
      proto_other <= w_byte[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_out = ce_in && !s_axi_rvalid_out;
  assign rd_idx            = s_axi_araddr_in[11:2];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    if (rd_idx == `CSDEC_PROTO_IDX) begin
      rd_byte = {4'h0, proto_other};
      rd_hit  = 1'b1;
    end
    if (rd_idx == `CSDEC_STATUS_IDX) begin
      rd_byte = {1'b0, wait_cnt, sel_active};
      rd_hit  = 1'b1;
    end
    for (int c = 0; c < CSDEC_CHANNELS; c++) begin
      if (rd_idx == LOW_IDX[c]) begin
        rd_byte = chan[c].range_low_byte;
        rd_hit  = 1'b1;
      end
      if (rd_idx == HIGH_IDX[c]) begin
        rd_byte = chan[c].range_high_byte;
        rd_hit  = 1'b1;
      end
      if (rd_idx == CTL_IDX[c]) begin
        rd_byte = {chan[c].wait_state_count, chan[c].io_type_flag,
                   chan[c].select_enable_flag, `CSDEC_RSVD_BITS};
        rd_hit  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `CSDEC_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {24'h00_0000, rd_byte};
      s_axi_rresp_out  <= rd_hit ? `CSDEC_RESP_OKAY : `CSDEC_RESP_SLVERR;
    end else if (ce_in && s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Select priority
  // ----------------------------------------------------------------
  // Overlapping ranges are a setup error; lowest channel wins so
  // only one device ever sees its select.
  always_comb begin
    winner    = 4'h0;
    next_wait = 3'h0;
    for (int c = CSDEC_CHANNELS - 1; c >= 0; c--) begin
      if (hit[c]) begin
        winner    = 4'h0;
        winner[c] = 1'b1;
        next_wait = proto_other[c] ? 3'h0 : chan[c].wait_state_count;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_active <= 4'h0;
    end else if (ce_in) begin
      sel_active <= winner;
    end
  end

  assign select_output_line_b_out = ~sel_active;

  // ----------------------------------------------------------------
  // Wait-state counter
  // ----------------------------------------------------------------
  assign req_now      = bus_req_in.mem_req || bus_req_in.io_req;
  assign access_start = req_now && !req_prev;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_prev <= 1'b0;
    end else if (ce_in) begin
      req_prev <= req_now;
    end
  end

  // Loaded once per access; a request held across a range change
  // keeps the count taken at its start.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_cnt <= 3'h0;
    end else if (ce_in) begin
      if (access_start) begin
        wait_cnt <= next_wait;
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end

  // Flag from a flop, so the pin stays clean while the count moves;
  // it looks one step ahead to keep the same cycle as the count.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_request_out <= 1'b0;
    end else if (ce_in) begin
      if (access_start) begin
        wait_request_out <= (next_wait != 3'h0);
      end else begin
        wait_request_out <= (wait_cnt > 3'h1);
      end
    end
  end

endmodule

// ---- dv/csdec_far_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Memories and peripherals behind selects
// ----------------------------------------
module csdec_far_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Selects seen, sticky so a short pulse is not lost
  input  wire logic [3:0] select_b_in,
  output logic      [3:0] seen_out
);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) seen_out <= 4'h0;
    else seen_out <= seen_out | ~select_b_in;
  end
endmodule

// ---- dv/csdec_top_asserts.sv ----
`timescale 1ns/10ps
`include "csdec_map.svh"
module csdec_top_asserts
  import csdec_pkg::*;
(
  // Clock, reset and enable
  input wire logic           clk_in,
  input wire logic           rst_b_in,
  input wire logic           ce_in,
  // Register bus
  input wire logic           s_axi_awvalid_in,
  input wire logic           s_axi_awready_out,
  input wire logic [1:0]     s_axi_bresp_out,
  input wire logic           s_axi_bvalid_out,
  input wire logic           s_axi_bready_in,
  input wire logic [11:0]    s_axi_araddr_in,
  input wire logic           s_axi_arvalid_in,
  input wire logic           s_axi_arready_out,
  input wire logic [31:0]    s_axi_rdata_out,
  input wire logic           s_axi_rvalid_out,
  input wire logic           s_axi_rready_in,
  // Decoder
  input wire csdec_bus_req_t bus_req_in,
  input wire logic [3:0]     select_output_line_b_out,
  input wire logic           wait_request_out
);
  // ----------------------------------------
  // Helpers: reset config still intact, read of a control byte
  // ----------------------------------------
  logic touched;
  logic rd_ctl;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      touched <= 1'b0;
      rd_ctl  <= 1'b0;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) touched <= 1'b1;
      if (s_axi_arvalid_in && s_axi_arready_out) rd_ctl <= s_axi_araddr_in[11:2] inside
        {`CSDEC_SEL0_CTL_IDX, `CSDEC_SEL1_CTL_IDX, `CSDEC_SEL2_CTL_IDX, `CSDEC_SEL3_CTL_IDX};
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_sel_single: assert property ($onehot0(~select_output_line_b_out))
    else $error("more than one select active");
  a_idle_no_sel: assert property (ce_in && !bus_req_in.mem_req && !bus_req_in.io_req
    |=> select_output_line_b_out == 4'hF) else $error("select without request");
  a_dflt_mem_sel: assert property (ce_in && !touched && bus_req_in.mem_req
    |=> select_output_line_b_out == 4'hE) else $error("default select 0 missed");
  a_dflt_wait_len: assert property (ce_in && !touched && !bus_req_in.io_req
    && $rose(bus_req_in.mem_req) |=> wait_request_out [*7] ##1 !wait_request_out)
    else $error("default wait length wrong");
  a_ctl_rsvd_zero: assert property (s_axi_rvalid_out && rd_ctl
    |-> s_axi_rdata_out[2:0] == 3'h0) else $error("reserved bits not zero");
  a_b_hold: assert property (s_axi_bvalid_out && !(s_axi_bready_in && ce_in)
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_r_hold: assert property (s_axi_rvalid_out && !(s_axi_rready_in && ce_in)
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  a_ar_answer: assert property (ce_in && s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read not answered");
  c_dflt_access: cover property (!touched && bus_req_in.mem_req ##1 wait_request_out);
  c_io_hit: cover property (bus_req_in.io_req ##1 select_output_line_b_out != 4'hF);
  c_wait_run: cover property (wait_request_out [*7]);
endmodule

bind csdec_top csdec_top_asserts csdec_top_asserts_inst (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .bus_req_in(bus_req_in), .select_output_line_b_out(select_output_line_b_out),
  .wait_request_out(wait_request_out));

// ---- dv/csdec_top_tb.sv ----
`timescale 1ns/10ps
`include "csdec_map.svh"
module csdec_top_tb
  import csdec_pkg::*;
;
  logic           clk, rst_b, ce, awv, wv, bready, arv, rready;
  logic           awready, wready, bvalid, arready, rvalid, wait_req;
  logic [11:0]    awaddr, araddr;
  logic [31:0]    wdata, rdata, rdat, seed, x;
  logic [1:0]     bresp, rresp, resp;
  logic [3:0]     wstrb, sel_b, seen;
  logic [7:0]     lo [4], hi [4], ctl [4];
  logic [23:0]    na;
  csdec_bus_req_t req;
  int             bad_count, n_compared, cnt, j;
  csdec_top csdec_top_inst (
    .clk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .bus_req_in(req), .select_output_line_b_out(sel_b),
    .wait_request_out(wait_req));
  csdec_far_model csdec_far_model_inst (
    .clk_in(clk), .rst_b_in(rst_b), .select_b_in(sel_b), .seen_out(seen));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] ra(int c, int f);
    return {10'(`CSDEC_SEL0_LOW_IDX + 3 * c + f), 2'b00};
  endfunction
  function automatic logic [31:0] rv(int c, int f);
    if (c == 0 && f == 1) return 32'hFF;
    if (c == 0 && f == 2) return 32'hE8;
    return 32'h0;
  endfunction
  // Lowest hitting channel wins
  function automatic logic [3:0] exp_sel(logic [23:0] a, logic m, logic i);
    logic h;
    exp_sel = 4'hF;
    for (int c = 3; c >= 0; c--) begin
      h = ctl[c][3] && (ctl[c][4] ? (i && a[15:8] == lo[c])
        : (m && a[23:16] >= lo[c] && a[23:16] <= hi[c]));
      if (h) exp_sel = ~(4'h1 << c);
    end
  endfunction
  task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_sel(string n, logic [3:0] e, logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Ready raised late on purpose, so the slave must hold its answer
  task automatic wr(logic [11:0] a, logic [7:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    resp = rresp;
    rdat = rdata;
    rready <= 1'b0;
  endtask
  task automatic mwait();
    @(posedge clk);
    req <= '{addr: 24'(nxt()), mem_req: 1'b1, io_req: 1'b0};
    cnt = 0;
    repeat (12) begin
      @(posedge clk);
      if (wait_req === 1'b1) cnt++;
    end
    req.mem_req <= 1'b0;
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    {rst_b, awv, wv, bready, arv, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    req = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    seed = 32'hA67A;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    mwait();
    chk_val("wait cycles", 7, cnt);
    chk_sel("select", 4'hE, sel_b);
    chk_sel("devices", 4'h1, seen);
    // Enable low: a request must neither select nor start a wait
    @(posedge clk);
    ce <= 1'b0;
    req.mem_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk_sel("frozen select", 4'hF, sel_b);
    chk_val("frozen wait", 0, {31'h0, wait_req});
    chk_val("frozen readies", 0, {29'h0, awready, wready, arready});
    @(posedge clk);
    ce <= 1'b1;
    req.mem_req <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int f = 0; f < 3; f++) begin
        rd(ra(c, f));
        chk_val("reset value", rv(c, f), rdat);
      end
    end
    $display("test reset_values done");
    wr(12'(`CSDEC_PROTO_IDX * 4), 8'h01);
    mwait();
    chk_val("wait cycles", 0, cnt);
    wr(12'(`CSDEC_PROTO_IDX * 4), 8'h00);
    wr(12'(`CSDEC_STATUS_IDX * 4), 8'hFF);
    chk_val("status write resp", 0, {30'h0, resp});
    // Held request: channel 0 selected, its wait long run out
    @(posedge clk);
    req.mem_req <= 1'b1;
    repeat (10) @(posedge clk);
    rd(12'(`CSDEC_STATUS_IDX * 4));
    chk_val("busy status", 32'h01, rdat);
    req.mem_req <= 1'b0;
    wr(ra(1, 2), 8'hFF);
    rd(ra(1, 2));
    chk_val("control", 32'hF8, rdat);
    wr(12'h000, 8'h55);
    chk_val("write resp", 32'h2, {30'h0, resp});
    rd(12'h000);
    chk_val("read resp", 32'h2, {30'h0, resp});
    $display("test fields done");
    // Addresses cluster round the bounds, where off-by-one slips show
    for (int r = 0; r < 20; r++) begin
      for (int c = 0; c < 4; c++) begin
        x = nxt();
        lo[c] = x[7:0];
        hi[c] = x[7:0] + 8'(x[9:8]);
        ctl[c] = {x[15:11], 3'h0};
        wr(ra(c, 0), lo[c]);
        wr(ra(c, 1), hi[c]);
        wr(ra(c, 2), ctl[c]);
        rd(ra(c, 2));
        chk_val("control", {24'h0, ctl[c]}, rdat);
      end
      repeat (20) begin
        x = nxt();
        j = x[1:0];
        na = {lo[j] + 8'(x[3:2]) - 8'h01, x[4] ? lo[j] : x[15:8], x[23:16]};
        @(posedge clk);
        req <= '{addr: na, mem_req: x[5], io_req: x[6]};
        @(posedge clk);
        #1 chk_sel("select", exp_sel(na, x[5], x[6]), sel_b);
      end
    end
    $display("test random_decode done");
    conclude();
  end
endmodule
